// ==== logic/tss_defines.svh ====
// register offsets, field positions, reset values and counts for the trigger sequencer
`ifndef TSS_DEFINES_SVH
`define TSS_DEFINES_SVH
`define TSS_OFF_CTRL      8'h00
`define TSS_OFF_C0LIM     8'h04
`define TSS_OFF_C1LIM     8'h08
`define TSS_OFF_ADJ       8'h0C
`define TSS_OFF_LIT       8'h10
`define TSS_OFF_QPTR      8'h14
`define TSS_OFF_T0LIM     8'h18
`define TSS_OFF_T1LIM     8'h1C
`define TSS_OFF_SDLIM     8'h20
`define TSS_OFF_HOLD      8'h24
`define TSS_OFF_BTE       8'h28
`define TSS_OFF_STATUS    8'h2C
`define TSS_OFF_QUE       8'h40
`define TSS_QUE_ENTRIES   16
`define TSS_CTRL_RUN_BIT  0
`define TSS_CTRL_SWT_BIT  1
`define TSS_REG_RESET     16'h0000
`define TSS_RESP_OKAY     2'b00
`define TSS_RESP_SLVERR   2'b10
`endif

// ==== logic/tss_pkg.sv ====
// types of the trigger sequencer
package tss_pkg;
  typedef enum logic [3:0] {
    TSS_IDLE  = 4'b0001,
    TSS_FETCH = 4'b0010,
    TSS_WAIT  = 4'b0100,
    TSS_DELAY = 4'b1000
  } tss_state_t;
endpackage

// ==== logic/tss_trigger_step_sequencer.sv ====
// trigger step sequencer: queue executor with an axi4-lite register slave
// Operation
// RULE1: registers read-only while the sequencer runs; here the control register (run and software trigger bits) stays writable
// RULE2: counter limits give loop count and limit
// RULE3: adjust value is added into targets
// RULE4: pointer names current step, upper bits zero
// RULE5: sixteen pairs, odd step high byte
// RULE6: opcode 0000 is control, operand 0000 nop
// RULE7: add adjust to six targets in order
// RULE8: copy hold value to six targets
// RULE9: opcode 001x strobes adc with channel
// RULE10: wait for rising or falling trigger input
// RULE11: reserved codes execute as no-operation
// RULE12: opcode 0111 raises one of eight interrupts
// RULE13: opcode 100x pulses one of 32 outputs
// RULE14: opcode 101x jumps to five-bit step
// RULE15: counted jumps loop until counter reaches limit
// RULE16: control 0010 disables, 0110 enables step delay
// RULE17: control 1000/1001 start timer, wait for match
// RULE18: software trigger level or rising edge wait
// RULE19: control 1100/1101 put counter limit on strobe bus
// RULE20: control 1111 broadcasts masked trigger outputs
// RULE21: sixteen trigger inputs from far peripherals
// RULE22: byte high nibble opcode, low nibble operand
// RULE23: step delay adds limit clocks per step; here TSS_DELAY lasts sdlim_q + 1 clocks
// RULE24: run bit starts continuous execution, clear stops
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "tss_defines.svh"
module tss_trigger_step_sequencer (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic [15:0] i_trigger_input,
  output logic [31:0]      o_trigger_output,
  output logic [7:0]       o_irq_pulse,
  output logic             o_adc_strobe,
  output logic [4:0]       o_adc_channel,
  output logic [15:0]      o_strobe_bus,
  output logic             o_strobe_bus_valid,
  output logic             o_running
);
  logic [15:0] c0lim_q, c1lim_q, adj_q, lit_q, t0lim_q, t1lim_q, sdlim_q, hold_q;
  logic [31:0] bte_q;
  logic [4:0]  qptr_q;
  logic [15:0] que_q [`TSS_QUE_ENTRIES];
  logic        run_q, swt_q, swt_prev_q, sd_en_q;
  logic [15:0] cnt0_q, cnt1_q, tmr_q, sd_cnt_q;
  logic [15:0] trig_prev_q;
  tss_pkg::tss_state_t state_q;
  logic [7:0]  cmd_q;
  // register slave state
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire, busy;
  logic [5:0]  wr_word;
  logic [31:0] wmask;
  logic [15:0] wnew;
  assign busy = (state_q != tss_pkg::TSS_IDLE);
  assign o_running = busy;
  // one write at a time: hold address and data until both are in
  assign o_s_axi_awready = !aw_hold_q && !o_s_axi_bvalid;
  assign o_s_axi_wready  = !w_hold_q && !o_s_axi_bvalid;
  assign wr_fire = aw_hold_q && w_hold_q && !o_s_axi_bvalid;
  assign wr_word = aw_addr_q[7:2];
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  // capture write channels in either order
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `TSS_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (aw_addr_q > (`TSS_OFF_QUE + 8'h3C)) ? `TSS_RESP_SLVERR : `TSS_RESP_OKAY;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end
  // merge write data under byte strobes for a 16-bit register
  function automatic logic [15:0] tss_merge(input logic [15:0] old);
    tss_merge = (old & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
  endfunction
  // read channel: one cycle after arvalid, data from flops
  assign o_s_axi_arready = !o_s_axi_rvalid;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h00000000;
      o_s_axi_rresp  <= `TSS_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= `TSS_RESP_OKAY;
      case (i_s_axi_araddr[7:2])
        `TSS_OFF_CTRL   >> 2: o_s_axi_rdata <= {30'h0, swt_q, run_q};
        `TSS_OFF_C0LIM  >> 2: o_s_axi_rdata <= {16'h0, c0lim_q};
        `TSS_OFF_C1LIM  >> 2: o_s_axi_rdata <= {16'h0, c1lim_q};
        `TSS_OFF_ADJ    >> 2: o_s_axi_rdata <= {16'h0, adj_q};
        `TSS_OFF_LIT    >> 2: o_s_axi_rdata <= {16'h0, lit_q};
        `TSS_OFF_QPTR   >> 2: o_s_axi_rdata <= {27'h0, qptr_q}; // RULE4
        `TSS_OFF_T0LIM  >> 2: o_s_axi_rdata <= {16'h0, t0lim_q};
        `TSS_OFF_T1LIM  >> 2: o_s_axi_rdata <= {16'h0, t1lim_q};
        `TSS_OFF_SDLIM  >> 2: o_s_axi_rdata <= {16'h0, sdlim_q};
        `TSS_OFF_HOLD   >> 2: o_s_axi_rdata <= {16'h0, hold_q};
        `TSS_OFF_BTE    >> 2: o_s_axi_rdata <= bte_q;
        `TSS_OFF_STATUS >> 2: o_s_axi_rdata <= {16'h0, sd_en_q, 11'h0, state_q};
        default: begin
          if (i_s_axi_araddr[7:6] == 2'b01) begin
            o_s_axi_rdata <= {16'h0, que_q[i_s_axi_araddr[5:2]]};
          end else begin
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `TSS_RESP_SLVERR;
          end
        end
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end
  // execution decode of the current step byte
  logic [3:0] opc, opr;
  logic [4:0] target;
  assign opc = cmd_q[7:4]; // RULE22
  assign opr = cmd_q[3:0]; // RULE22
  assign target = {opc[0], opr};
  logic [7:0] fetch_byte;
  // RULE5: even step in low byte, odd step in high byte
  assign fetch_byte = qptr_q[0] ? que_q[qptr_q[4:1]][15:8] : que_q[qptr_q[4:1]][7:0];
  // decides whether the current step has finished waiting
  logic wait_done, cnt_hit, cnt_eq0, cnt_eq1, step_end;
  assign cnt_eq0 = (cnt0_q == c0lim_q); // RULE2
  assign cnt_eq1 = (cnt1_q == c1lim_q); // RULE2
  always_comb begin
    wait_done = 1'b1;
    if (opc == 4'b0100) begin
      wait_done = i_trigger_input[opr] && !trig_prev_q[opr]; // RULE10
    end else if (opc == 4'b0101) begin
      wait_done = !i_trigger_input[opr] && trig_prev_q[opr]; // RULE10
    end else if (opc == 4'b0000) begin
      case (opr)
        4'b1000: wait_done = (tmr_q == t0lim_q); // RULE17
        4'b1001: wait_done = (tmr_q == t1lim_q); // RULE17
        4'b1010: wait_done = swt_q; // RULE18
        4'b1011: wait_done = swt_q && !swt_prev_q; // RULE18
        default: wait_done = 1'b1; // RULE6 RULE11
      endcase
    end
    cnt_hit = opc[1] ? cnt_eq1 : cnt_eq0;
  end
  // sequencer state machine and queue pointer
  assign step_end = (state_q == tss_pkg::TSS_WAIT && wait_done && !sd_en_q) ||
                    (state_q == tss_pkg::TSS_DELAY && sd_cnt_q == sdlim_q);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= tss_pkg::TSS_IDLE;
      cmd_q   <= 8'h00;
    end else begin
      case (state_q)
        tss_pkg::TSS_IDLE:  if (run_q) state_q <= tss_pkg::TSS_FETCH; // RULE24
        tss_pkg::TSS_FETCH: begin
          cmd_q   <= fetch_byte;
          state_q <= tss_pkg::TSS_WAIT;
        end
        tss_pkg::TSS_WAIT: begin
          if (wait_done) state_q <= sd_en_q ? tss_pkg::TSS_DELAY : tss_pkg::TSS_FETCH;
        end
        tss_pkg::TSS_DELAY: if (sd_cnt_q == sdlim_q) state_q <= tss_pkg::TSS_FETCH; // RULE23
        default: state_q <= tss_pkg::TSS_IDLE;
      endcase
      // clearing the run bit stops execution at once, mid-step
      if (!run_q) state_q <= tss_pkg::TSS_IDLE; // RULE24
    end
  end
  // step delay counter counts extra clocks after the step's own work
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || state_q != tss_pkg::TSS_DELAY) begin
      sd_cnt_q <= 16'h0000;
    end else begin
      sd_cnt_q <= sd_cnt_q + 16'h0001; // RULE23
    end
  end
  // general timer shared by the two timer waits, cleared on every fetch
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || state_q == tss_pkg::TSS_FETCH) begin
      tmr_q <= 16'h0000;
    end else if (state_q == tss_pkg::TSS_WAIT && opc == 4'b0000 && opr[3:1] == 3'b100 &&
                 !wait_done) begin
      tmr_q <= tmr_q + 16'h0001; // RULE17
    end
  end
  // edge history for trigger inputs and software trigger
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      trig_prev_q <= 16'h0000;
      swt_prev_q  <= 1'b0;
    end else begin
      trig_prev_q <= i_trigger_input; // RULE21
      swt_prev_q  <= swt_q;
    end
  end
  // first cycle of wait state is where one-shot effects happen
  logic exec_q, exec_now;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) exec_q <= 1'b0;
    else exec_q <= (state_q == tss_pkg::TSS_FETCH);
  end
  assign exec_now = exec_q && state_q == tss_pkg::TSS_WAIT;
  // pulse outputs, one cycle each; adc channel and strobe bus value hold until the next load
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_trigger_output   <= 32'h00000000;
      o_irq_pulse        <= 8'h00;
      o_adc_strobe       <= 1'b0;
      o_adc_channel      <= 5'h00;
      o_strobe_bus       <= 16'h0000;
      o_strobe_bus_valid <= 1'b0;
    end else begin
      o_trigger_output   <= 32'h00000000;
      o_irq_pulse        <= 8'h00;
      o_adc_strobe       <= 1'b0;
      o_strobe_bus_valid <= 1'b0;
      if (exec_now) begin
        if (opc[3:1] == 3'b001) begin
          o_adc_strobe  <= 1'b1; // RULE9
          o_adc_channel <= target; // RULE9
        end
        if (opc == 4'b0111 && !opr[3]) o_irq_pulse[opr[2:0]] <= 1'b1; // RULE12 RULE11
        if (opc[3:1] == 3'b100) o_trigger_output[target] <= 1'b1; // RULE13
        if (opc == 4'b0000 && opr == 4'b1111) o_trigger_output <= bte_q; // RULE20
        if (opc == 4'b0000 && opr[3:1] == 3'b110) begin
          o_strobe_bus       <= opr[0] ? c1lim_q : c0lim_q; // RULE19
          o_strobe_bus_valid <= 1'b1;
        end
      end
    end
  end
  // loop counters move at step end, with the jump decision, so a delay cannot skew them
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !busy) begin
      cnt0_q <= 16'h0000;
      cnt1_q <= 16'h0000;
    end else if (step_end && opc[3:2] == 2'b11 && !cnt_hit) begin
      if (opc[1]) cnt1_q <= cnt1_q + 16'h0001; // RULE15
      else cnt0_q <= cnt0_q + 16'h0001; // RULE15
    end else if (step_end && opc[3:2] == 2'b11) begin
      // counter rearms once the loop falls through
      if (opc[1]) cnt1_q <= 16'h0000;
      else cnt0_q <= 16'h0000;
    end
  end
  // queue pointer: software while idle, sequencer while running
  assign wnew = ({11'h0, qptr_q} & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      qptr_q <= 5'h00;
    end else if (busy) begin
      if (step_end) begin
        if (opc[3:1] == 3'b101) qptr_q <= target; // RULE14
        else if (opc[3:2] == 2'b11 && !cnt_hit) qptr_q <= target; // RULE15
        else qptr_q <= qptr_q + 5'h01; // RULE4
      end
    end else if (wr_fire && wr_word == (`TSS_OFF_QPTR >> 2)) begin
      qptr_q <= wnew[4:0]; // RULE1
    end
  end
  // queue storage, one generate entry per pair
  genvar gi;
  for (gi = 0; gi < `TSS_QUE_ENTRIES; gi++) begin : g_que
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) que_q[gi] <= `TSS_REG_RESET;
      else if (wr_fire && !busy && wr_word == 6'(16 + gi)) que_q[gi] <= tss_merge(que_q[gi]); // RULE1 RULE5
    end
  end
  // add and copy operands share a target order; hold and adjust differ
  logic arith, arith_en;
  logic [2:0] arith_sel;
  assign arith_en = exec_now && opc == 4'b0001 && opr[2:0] <= 3'd5 && opr[2:1] != 2'b11; // RULE11
  assign arith = opr[3];
  assign arith_sel = opr[2:0];
  function automatic logic [15:0] tss_apply(input logic [15:0] cur);
    tss_apply = arith ? hold_q : cur + adj_q; // RULE3 RULE7 RULE8
  endfunction
  // configuration registers: writes ignored while running
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      c0lim_q <= `TSS_REG_RESET;
      c1lim_q <= `TSS_REG_RESET;
      adj_q   <= `TSS_REG_RESET;
      lit_q   <= `TSS_REG_RESET;
      t0lim_q <= `TSS_REG_RESET;
      t1lim_q <= `TSS_REG_RESET;
      sdlim_q <= `TSS_REG_RESET;
      hold_q  <= `TSS_REG_RESET;
      bte_q   <= 32'h00000000;
    end else if (busy) begin
      if (arith_en) begin
        case (arith_sel)
          3'd0: c0lim_q <= tss_apply(c0lim_q); // RULE7 RULE8
          3'd1: c1lim_q <= tss_apply(c1lim_q);
          3'd2: t0lim_q <= tss_apply(t0lim_q);
          3'd3: t1lim_q <= tss_apply(t1lim_q);
          3'd4: sdlim_q <= tss_apply(sdlim_q);
          3'd5: lit_q   <= tss_apply(lit_q);
          default: ;
        endcase
      end
    end else if (wr_fire) begin
      case (wr_word) // RULE1
        `TSS_OFF_C0LIM >> 2: c0lim_q <= tss_merge(c0lim_q);
        `TSS_OFF_C1LIM >> 2: c1lim_q <= tss_merge(c1lim_q);
        `TSS_OFF_ADJ   >> 2: adj_q   <= tss_merge(adj_q);
        `TSS_OFF_LIT   >> 2: lit_q   <= tss_merge(lit_q);
        `TSS_OFF_T0LIM >> 2: t0lim_q <= tss_merge(t0lim_q);
        `TSS_OFF_T1LIM >> 2: t1lim_q <= tss_merge(t1lim_q);
        `TSS_OFF_SDLIM >> 2: sdlim_q <= tss_merge(sdlim_q);
        `TSS_OFF_HOLD  >> 2: hold_q  <= tss_merge(hold_q);
        `TSS_OFF_BTE   >> 2: bte_q   <= (bte_q & ~wmask) | (w_data_q & wmask);
        default: ;
      endcase
    end
  end
  // control bits stay writable at all times so software can stop and trigger
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      run_q   <= 1'b0;
      swt_q   <= 1'b0;
      sd_en_q <= 1'b0;
    end else begin
      if (wr_fire && wr_word == (`TSS_OFF_CTRL >> 2) && w_strb_q[0]) begin
        run_q <= w_data_q[`TSS_CTRL_RUN_BIT]; // RULE24
        swt_q <= w_data_q[`TSS_CTRL_SWT_BIT]; // RULE18
      end
      if (exec_now && opc == 4'b0000 && opr == 4'b0010) sd_en_q <= 1'b0; // RULE16
      if (exec_now && opc == 4'b0000 && opr == 4'b0110) sd_en_q <= 1'b1; // RULE16
    end
  end
  // checks
  a_ro_while_busy: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
    busy && $past(busy) && !exec_now && !$past(exec_now) |-> $stable(adj_q))
    else $error("adjust changed while running");
  a_qptr_jump: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE14
    busy && step_end && opc[3:1] == 3'b101 && run_q |=> qptr_q == $past(target))
    else $error("jump target not loaded");
  a_trig_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE13
    exec_now && opc[3:1] == 3'b100 |=> o_trigger_output[$past(target)])
    else $error("trigger output missing");
  a_irq_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE12
    exec_now && opc == 4'b0111 && opr[3] |=> o_irq_pulse == 8'h00)
    else $error("reserved irq operand raised an interrupt");
  a_adc_strobe: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE9
    exec_now && opc[3:1] == 3'b001 |=> o_adc_strobe && o_adc_channel == $past(target))
    else $error("adc strobe wrong");
  a_stop_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE24
    !run_q |=> state_q == tss_pkg::TSS_IDLE)
    else $error("sequencer ran with run bit low");
  a_strobe_bus: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE19
    exec_now && opc == 4'b0000 && opr == 4'b1100 |=> o_strobe_bus == $past(c0lim_q))
    else $error("strobe bus value wrong");
  a_sd_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE16
    exec_now && opc == 4'b0000 && opr == 4'b0110 |=> sd_en_q)
    else $error("step delay not enabled");
  a_broadcast: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE20
    exec_now && opc == 4'b0000 && opr == 4'b1111 |=> o_trigger_output == $past(bte_q))
    else $error("broadcast mismatch");
endmodule

// ==== test/tss_periph_model.sv ====
// far-side peripheral sources that feed the sequencer trigger inputs
`timescale 1ns/1ps
module tss_periph_model (
  input  wire logic   i_core_clk,
  input  wire logic   i_rst_n,
  output logic [15:0] o_trigger_input
);
  logic [7:0] tick_q;

  // free-running phase counter, every source is a periodic waveform of it
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tick_q <= 8'h00;
    end else begin
      tick_q <= tick_q + 8'h01;
    end
  end

  // pwm channels on 0-3; capture, comparator and cell sources on 7-13; interrupt on 15
  // reserved inputs 4-6 and 14 never toggle, so a stray wait on them would hang
  always_comb begin
    o_trigger_input        = 16'h0000;
    o_trigger_input[3:0]   = tick_q[4:1];
    o_trigger_input[13:7]  = tick_q[7:1];
    o_trigger_input[15]    = tick_q[5];
  end
endmodule

// ==== test/tss_trigger_step_sequencer_tb.sv ====
// self-checking bench: register access, queue programs and far-side waits
`timescale 1ns/1ps
`include "tss_defines.svh"
module tss_trigger_step_sequencer_tb;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic        awvalid   = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic [7:0]  araddr    = 8'h00;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, adc_stb, sbus_vld, running;
  logic [1:0]  bresp, rresp, r, wr_resp;
  logic [31:0] rdata, trig_out, last_trig, d;
  logic [15:0] trig_in, sbus, last_sbus;
  logic [7:0]  irq;
  logic [4:0]  adc_ch, last_ch;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          n_t31 = 0;
  int          n_irq3 = 0;
  int          n_irqx = 0;
  int          n_adc = 0;
  logic [15:0] prog_a [8] = '{16'h9F10, 16'h733A, 16'h4F0C, 16'hC168,
                              16'h7F0A, 16'hAE1D, 16'h7373, 16'h000B};
  logic [15:0] prog_b [3] = '{16'h0806, 16'h5F0F, 16'h0B02};

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  tss_trigger_step_sequencer dut (
    .i_core_clk(core_clk), .i_rst_n(rst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_trigger_input(trig_in),
    .o_trigger_output(trig_out), .o_irq_pulse(irq), .o_adc_strobe(adc_stb),
    .o_adc_channel(adc_ch), .o_strobe_bus(sbus), .o_strobe_bus_valid(sbus_vld),
    .o_running(running)
  );

  tss_periph_model periph (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .o_trigger_input(trig_in)
  );

  // tally one-cycle pulses; they are gone a cycle later so every edge is seen
  always @(posedge core_clk) begin
    if (rst_n === 1'b1) begin
      if (trig_out[31] === 1'b1) n_t31++;
      if (trig_out !== 32'h0) last_trig <= trig_out;
      if (irq[3] === 1'b1) n_irq3++;
      if ((irq & 8'hF7) !== 8'h00) n_irqx++;
      if (adc_stb === 1'b1) n_adc++;
      if (adc_stb === 1'b1) last_ch <= adc_ch;
      if (sbus_vld === 1'b1) last_sbus <= sbus;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one write: address and data offered together, each dropped once taken;
  // handshakes are sampled on the falling edge where the bus is settled
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge core_clk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = (bvalid === 1'b1);
      if (b_t) wr_resp = bresp;
      @(posedge core_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge core_clk);
      ar_t = arvalid & arready;
      r_t = (rvalid === 1'b1);
      v = rdata;
      s = rresp;
      @(posedge core_clk);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  s;
    axr(a, v, s);
    chk(nm, e, v);
  endtask

  // poll the pointer until the sequencer parks on the expected step
  task automatic poll_ptr(input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  s;
    for (int k = 0; k < 100; k++) begin
      axr(`TSS_OFF_QPTR, v, s);
      if (v === e) break;
    end
    chk("queue pointer", e, v);
  endtask

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog: the tests need a few hundred cycles, this allows twenty thousand
  initial begin
    #500000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 1; i < 6; i++) begin
      rchk("reset value", 8'(4 * i), 32'h0);
    end
    axw(`TSS_OFF_QPTR, 32'hFFFF);
    rchk("pointer width", `TSS_OFF_QPTR, 32'h1F);
    axw(`TSS_OFF_QPTR, 32'h0);
    chk("write resp", {30'h0, `TSS_RESP_OKAY}, {30'h0, wr_resp});
    axr(8'h30, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped resp", {30'h0, `TSS_RESP_SLVERR}, {30'h0, r});
    axr(8'h80, d, r);
    chk("range resp", {30'h0, `TSS_RESP_SLVERR}, {30'h0, r});
    axw(8'h80, 32'h0);
    chk("range write resp", {30'h0, `TSS_RESP_SLVERR}, {30'h0, wr_resp});
    // program a: add, pulse, strobe, irq, wait rise, loop twice, copy, jump over irqs
    axw(`TSS_OFF_C0LIM, 32'h1);
    axw(`TSS_OFF_ADJ, 32'h1);
    axw(`TSS_OFF_HOLD, 32'hA5C3);
    for (int i = 0; i < 8; i++) begin
      axw(`TSS_OFF_QUE + 8'(4 * i), {16'h0, prog_a[i]});
    end
    rchk("queue pair", `TSS_OFF_QUE + 8'h0C, 32'hC168);
    axw(`TSS_OFF_CTRL, 32'h1);
    poll_ptr(32'h8);
    chk("running", 32'h1, {31'h0, running});
    axw(`TSS_OFF_ADJ, 32'h7777);
    rchk("locked adjust", `TSS_OFF_ADJ, 32'h1);
    axw(`TSS_OFF_CTRL, 32'h3);
    poll_ptr(32'hE);
    rchk("copied literal", `TSS_OFF_LIT, 32'hA5C3);
    rchk("added limit", `TSS_OFF_C0LIM, 32'h2);
    chk("trigger 31 pulses", 32'h3, n_t31);
    chk("irq 3 pulses", 32'h3, n_irq3);
    chk("other irq pulses", 32'h0, n_irqx);
    chk("adc strobes", 32'h3, n_adc);
    chk("adc channel", 32'h1A, {27'h0, last_ch});
    chk("strobe bus", 32'h2, {16'h0, last_sbus});
    chk("single trigger", 32'h80000000, last_trig);
    axw(`TSS_OFF_CTRL, 32'h0);
    // the state falls to idle at the very edge the write task returns on
    @(negedge core_clk);
    chk("stopped", 32'h0, {31'h0, running});
    axw(`TSS_OFF_ADJ, 32'h1234);
    rchk("idle adjust", `TSS_OFF_ADJ, 32'h1234);
    // program b: step delay on, timer wait, broadcast, wait fall, delay off, park
    axw(`TSS_OFF_QPTR, 32'h0);
    axw(`TSS_OFF_T0LIM, 32'h5);
    axw(`TSS_OFF_SDLIM, 32'h3);
    axw(`TSS_OFF_BTE, 32'h80001001);
    for (int i = 0; i < 3; i++) begin
      axw(`TSS_OFF_QUE + 8'(4 * i), {16'h0, prog_b[i]});
    end
    axw(`TSS_OFF_CTRL, 32'h1);
    poll_ptr(32'h5);
    chk("broadcast", 32'h80001001, last_trig);
    chk("broadcast count", 32'h4, n_t31);
    axw(`TSS_OFF_CTRL, 32'h0);
    end_sim();
  end
endmodule
